// ---- shared/wiper_defines.svh ----
`ifndef WIPER_DEFINES_SVH
`define WIPER_DEFINES_SVH

// register addresses
`define ADDR_WIPER_CH0 8'h00
`define ADDR_WIPER_CH1 8'h01
`define ADDR_ACCESS_CONTROL 8'h10
// reset values
`define WIPER_RESET 8'h80
`define ACCESS_CONTROL_RESET 8'h40
// field positions
`define POWER_DOWN_N_BIT 6
// fixed identification prefix (arbitrary value, not a real code)
`define ID_PREFIX 4'h5
// supply dip filter: 0.3 us at 5 ns clock
`define DIP_TIME_NS 300
`define CLK_PERIOD_NS 5
`define DIP_CYCLES ((`DIP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// wiper restore settling after shutdown exit, 1 us
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES (`SETTLE_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- shared/wiper_pkg.sv ----
package wiper_pkg;
  // serial engine phase
  typedef enum logic [2:0] {
    ph_idle,
    ph_id,
    ph_addr,
    ph_wdata,
    ph_rdata,
    ph_ack_out,
    ph_ack_in
  } phase_type;

  // tap control to one analog array
  typedef struct packed {
    logic [7:0] tap_new;   // tap being made
    logic [7:0] tap_old;   // tap being broken
    logic break_old;       // old tap released
    logic shutdown;        // array ends open, wiper to low
  } tap_ctrl_type;
endpackage : wiper_pkg

// ---- logic/tap_switch.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.svh"

// make-before-break sequencer for one wiper
module tap_switch (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] code,
  input wire logic power_down_n,
  output wiper_pkg::tap_ctrl_type ctrl
);
  logic [7:0] old_r, old_nxt;     // tap currently made
  logic [1:0] step_r, step_nxt;   // make-before-break step
  logic [7:0] settle_r, settle_nxt; // restore delay counter
  logic sd_r, sd_nxt;

  // next state
  always_comb begin
    old_nxt = old_r;
    step_nxt = step_r;
    settle_nxt = settle_r;
    sd_nxt = sd_r;
    if (!power_down_n) begin
      sd_nxt = 1'b1;
      settle_nxt = 8'(`SETTLE_CYCLES);
    end else if (sd_r) begin
      // hold shutdown until settling ends
      if (settle_r == 8'h00) begin
        sd_nxt = 1'b0;
        old_nxt = code;
      end else begin
        settle_nxt = settle_r - 8'h01;
      end
    end else if (code != old_r && step_r == 2'd0) begin
      step_nxt = 2'd1; // new tap made, old still held
    end else if (step_r == 2'd1) begin
      step_nxt = 2'd0;
      old_nxt = code; // now break the old one
    end
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      old_r <= `WIPER_RESET;
      step_r <= 2'd0;
      settle_r <= 8'h00;
      sd_r <= 1'b0;
    end else begin
      old_r <= old_nxt;
      step_r <= step_nxt;
      settle_r <= settle_nxt;
      sd_r <= sd_nxt;
    end
  end

  // code maps straight to tap index, one tap per step
  always_comb begin
    ctrl.tap_new = code;
    ctrl.tap_old = old_r;
    ctrl.break_old = (old_r == code);
    ctrl.shutdown = sd_r;
  end
endmodule : tap_switch

`default_nettype wire

// ---- logic/wiper_bank.sv ----
// Behaviour
// - two 8-bit wiper registers select taps
// - 00h low end, FFh high end
// - code maps monotonically, one tap per step
// - wipers reset to 80h
// - addresses 0, 1, 10h decoded
// - shutdown bit resets to 1, 40h
// - bit 6 shuts both channels
// - bit low asserts shutdown controls
// - shutdown keeps wiper codes
// - leaving shutdown restores taps after settling
// - supply dip in shutdown resets wipers
// - device is slave, master clocks
// - bytes travel MSB first
// - sample on rise, change after fall
// - straps give low three address bits
// - data pin driven low only
// - make new tap before breaking old
// - wipers writable and readable
// - id byte prefix, straps, direction
// - write updates register at ninth clock
// - further data bytes accepted
// - read ends on master not-acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.svh"

module wiper_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] address_straps,
  input wire logic supply_low,
  output wiper_pkg::tap_ctrl_type tap_ch0,
  output wiper_pkg::tap_ctrl_type tap_ch1
);
  // input synchronisers, first stage read only by second
  logic [1:0] scl_s1_r, scl_s2_r;
  logic [1:0] sda_s1_r, sda_s2_r;
  logic [2:0] strap_s1_r, strap_s2_r;
  logic [1:0] dip_s1_r, dip_s2_r;
  logic scl_d_r, sda_d_r; // previous synced levels
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // serial engine state
  wiper_pkg::phase_type ph_r, ph_nxt;
  wiper_pkg::phase_type after_r, after_nxt; // phase after ack
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic ack_now_r, ack_now_nxt;     // ack pending at next fall

  // register bank
  logic [7:0] wiper0_r, wiper0_nxt;
  logic [7:0] wiper1_r, wiper1_nxt;
  logic pdn_r, pdn_nxt;
  logic [8:0] dip_cnt_r, dip_cnt_nxt; // dip length counter

  logic [7:0] rd_val;
  logic [6:0] own_addr;
  logic write_ok_r, write_ok_nxt; // a data byte has been received
  logic write_ok;

  // two flip-flop synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_s1_r <= 2'b11;
      scl_s2_r <= 2'b11;
      sda_s1_r <= 2'b11;
      sda_s2_r <= 2'b11;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      dip_s1_r <= 2'b00;
      dip_s2_r <= 2'b00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= {1'b0, scl_in};
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= {1'b0, sda_in};
      sda_s2_r <= sda_s1_r;
      strap_s1_r <= address_straps;
      strap_s2_r <= strap_s1_r;
      dip_s1_r <= {1'b0, supply_low};
      dip_s2_r <= dip_s1_r;
      scl_d_r <= scl_s2_r[0];
      sda_d_r <= sda_s2_r[0];
    end
  end

  // line event detection on synced levels
  always_comb begin
    scl_rise = scl_s2_r[0] & ~scl_d_r;
    scl_fall = ~scl_s2_r[0] & scl_d_r;
    start_seen = scl_s2_r[0] & scl_d_r & sda_d_r & ~sda_s2_r[0];
    stop_seen = scl_s2_r[0] & scl_d_r & ~sda_d_r & sda_s2_r[0];
    own_addr = {`ID_PREFIX, strap_s2_r};
  end

  // readback mux, other control bits zero
  always_comb begin
    unique case (ptr_r)
      `ADDR_WIPER_CH0: rd_val = wiper0_r;
      `ADDR_WIPER_CH1: rd_val = wiper1_r;
      `ADDR_ACCESS_CONTROL: rd_val = {1'b0, pdn_r, 6'h00};
      default: rd_val = 8'h00;
    endcase
  end

  // serial engine and register writes
  always_comb begin
    ph_nxt = ph_r;
    after_nxt = after_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    ptr_nxt = ptr_r;
    sda_oe_nxt = sda_oe_r;
    ack_now_nxt = ack_now_r;
    wiper0_nxt = wiper0_r;
    wiper1_nxt = wiper1_r;
    pdn_nxt = pdn_r;
    dip_cnt_nxt = dip_cnt_r;
    // supply dip filter in shutdown only
    if (!pdn_r && dip_s2_r[0]) begin
      if (dip_cnt_r == 9'(`DIP_CYCLES)) begin
        wiper0_nxt = `WIPER_RESET;
        wiper1_nxt = `WIPER_RESET;
      end else begin
        dip_cnt_nxt = dip_cnt_r + 9'h001;
      end
    end else begin
      dip_cnt_nxt = 9'h000;
    end
    if (start_seen) begin
      // start or repeated start, release line
      ph_nxt = wiper_pkg::ph_id;
      bit_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
      ack_now_nxt = 1'b0;
    end else if (stop_seen) begin
      ph_nxt = wiper_pkg::ph_idle;
      sda_oe_nxt = 1'b0;
      ack_now_nxt = 1'b0;
    end else if (scl_rise) begin
      unique case (ph_r)
        wiper_pkg::ph_id, wiper_pkg::ph_addr, wiper_pkg::ph_wdata: begin
          shift_nxt = {shift_r[6:0], sda_s2_r[0]};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h7) begin
            ack_now_nxt = 1'b1;
            if (ph_r == wiper_pkg::ph_id) begin
              if (shift_r[6:0] == own_addr) begin
                after_nxt = sda_s2_r[0] ? wiper_pkg::ph_rdata : wiper_pkg::ph_addr;
              end else begin
                ack_now_nxt = 1'b0;
                ph_nxt = wiper_pkg::ph_idle; // not ours
              end
            end else if (ph_r == wiper_pkg::ph_addr) begin
              ptr_nxt = {shift_r[6:0], sda_s2_r[0]};
              after_nxt = wiper_pkg::ph_wdata;
            end else begin
              after_nxt = wiper_pkg::ph_wdata;
            end
          end
        end
        wiper_pkg::ph_ack_out: begin
          // ninth clock: commit write data
          // the address byte's ack must not move the pointer
          if (after_r == wiper_pkg::ph_wdata && bit_r == 4'h8 && write_ok) begin
            bit_nxt = 4'h9;
          end
        end
        wiper_pkg::ph_rdata: begin
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h7) begin
            ph_nxt = wiper_pkg::ph_ack_in;
          end
        end
        wiper_pkg::ph_ack_in: begin
          // master nack ends the read
          if (sda_s2_r[0]) begin
            ph_nxt = wiper_pkg::ph_idle;
          end else begin
            ph_nxt = wiper_pkg::ph_rdata;
            ptr_nxt = ptr_r + 8'h01;
            bit_nxt = 4'h0;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      // outputs change only after a falling edge
      if (ack_now_r) begin
        ack_now_nxt = 1'b0;
        sda_oe_nxt = 1'b1;
        ph_nxt = wiper_pkg::ph_ack_out;
        bit_nxt = 4'h8;
      end else if (ph_r == wiper_pkg::ph_ack_out) begin
        sda_oe_nxt = 1'b0;
        ph_nxt = after_r;
        bit_nxt = 4'h0;
        if (after_r == wiper_pkg::ph_rdata) begin
          sda_oe_nxt = ~rd_val[7];
          shift_nxt = {rd_val[6:0], 1'b0};
        end
        if (after_r == wiper_pkg::ph_wdata && ph_r == wiper_pkg::ph_ack_out && bit_r == 4'h9) begin
          ptr_nxt = ptr_r + 8'h01;
        end
      end else if (ph_r == wiper_pkg::ph_rdata) begin
        if (bit_r == 4'h8) begin
          sda_oe_nxt = 1'b0; // release for master ack
        end else if (bit_r == 4'h0) begin
          sda_oe_nxt = ~rd_val[7]; // next byte after ack
          shift_nxt = {rd_val[6:0], 1'b0};
        end else begin
          sda_oe_nxt = ~shift_r[7];
          shift_nxt = {shift_r[6:0], 1'b0};
        end
      end else if (ph_r == wiper_pkg::ph_ack_in) begin
        sda_oe_nxt = 1'b0;
      end
    end
    // register write at ninth rising clock of a data byte
    if (scl_rise && ph_r == wiper_pkg::ph_ack_out && after_r == wiper_pkg::ph_wdata && bit_r == 4'h8
        && !start_seen && !stop_seen) begin
      if (write_ok) begin
        unique case (ptr_r)
          `ADDR_WIPER_CH0: wiper0_nxt = shift_r;
          `ADDR_WIPER_CH1: wiper1_nxt = shift_r;
          `ADDR_ACCESS_CONTROL: pdn_nxt = shift_r[`POWER_DOWN_N_BIT];
          default: ;
        endcase
      end
    end
  end

  // write only after a data byte, not after id or address
  always_comb begin
    write_ok = write_ok_r;
    write_ok_nxt = write_ok_r;
    if (scl_rise && ph_r == wiper_pkg::ph_wdata && bit_r == 4'h7) begin
      write_ok_nxt = 1'b1;
    end else if (scl_rise && (ph_r == wiper_pkg::ph_id || ph_r == wiper_pkg::ph_addr)) begin
      write_ok_nxt = 1'b0;
    end
  end

  // engine and bank registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_r <= wiper_pkg::ph_idle;
      after_r <= wiper_pkg::ph_idle;
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      ptr_r <= 8'h00;
      sda_oe_r <= 1'b0;
      ack_now_r <= 1'b0;
      wiper0_r <= `WIPER_RESET;
      wiper1_r <= `WIPER_RESET;
      pdn_r <= 1'(`ACCESS_CONTROL_RESET >> `POWER_DOWN_N_BIT);
      dip_cnt_r <= 9'h000;
      write_ok_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      after_r <= after_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      ptr_r <= ptr_nxt;
      sda_oe_r <= sda_oe_nxt;
      ack_now_r <= ack_now_nxt;
      wiper0_r <= wiper0_nxt; // codes untouched by shutdown
      wiper1_r <= wiper1_nxt;
      pdn_r <= pdn_nxt;
      dip_cnt_r <= dip_cnt_nxt;
      write_ok_r <= write_ok_nxt;
    end
  end

  // open drain: only ever drive low
  always_comb begin
    sda_out = 1'b0;
    sda_oe = sda_oe_r;
  end

  // one sequencer per channel, shared shutdown
  tap_switch u_tap0 (
    .mclk(mclk),
    .rst(rst),
    .code(wiper0_r),
    .power_down_n(pdn_r),
    .ctrl(tap_ch0)
  );
  tap_switch u_tap1 (
    .mclk(mclk),
    .rst(rst),
    .code(wiper1_r),
    .power_down_n(pdn_r),
    .ctrl(tap_ch1)
  );
endmodule : wiper_bank

`default_nettype wire

// ---- dv/wiper_bank_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// pin-level watcher for the wiper bank
module wiper_bank_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] address_straps,
  input wire logic supply_low,
  input wire wiper_pkg::tap_ctrl_type tap_ch0,
  input wire wiper_pkg::tap_ctrl_type tap_ch1
);
  logic [6:0] dip_r, dip_nxt; // dip run in shutdown
  logic [4:0] hi_r, hi_nxt; // clock-high run
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // saturating runs, so a long idle never wraps
  always_comb begin
    dip_nxt = (supply_low && tap_ch0.shutdown) ? dip_r + 7'(dip_r != 7'h7f) : 7'h00;
    hi_nxt = scl_in ? hi_r + 5'(hi_r != 5'h1f) : 5'h00;
  end
  // register the runs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dip_r <= 7'h00;
      hi_r <= 5'h00;
    end else begin
      dip_r <= dip_nxt;
      hi_r <= hi_nxt;
    end
  end
  // old tap held a little, then broken
  sequence make_then_break(b);
    ##[0:1] !b ##[1:4] b;
  endsequence
  a_sda_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_shutdown_both: assert property (tap_ch0.shutdown == tap_ch1.shutdown)
    else $error("channels differ in shutdown");
  // taps are open in shutdown, so a code change there is not switched
  a_mbb_ch0: assert property ($changed(tap_ch0.tap_new) && !tap_ch0.shutdown
    |-> make_then_break(tap_ch0.break_old)) else $error("ch0 broke before make");
  a_mbb_ch1: assert property ($changed(tap_ch1.tap_new) && !tap_ch1.shutdown
    |-> make_then_break(tap_ch1.break_old)) else $error("ch1 broke before make");
  a_reset_mid: assert property ($fell(rst) |-> tap_ch0.tap_new == 8'h80 && tap_ch1.tap_new == 8'h80
    && !tap_ch0.shutdown && !sda_oe) else $error("bad state after reset");
  a_oe_on_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  a_dip_reset: assert property (dip_r == 7'h48 |-> ##[0:8]
    (tap_ch0.tap_new == 8'h80 && tap_ch1.tap_new == 8'h80)) else $error("dip kept wipers");
  a_idle_release: assert property (hi_r == 5'h10 |-> !sda_oe)
    else $error("data held with no clocking");
  a_settle_kept: assert property ($fell(tap_ch1.shutdown) |-> $past(tap_ch1.shutdown, 150))
    else $error("shutdown left without settling");
endmodule : wiper_bank_chk
bind wiper_bank wiper_bank_chk chk (.mclk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
  .address_straps, .supply_low, .tap_ch0, .tap_ch1);
`default_nettype wire

// ---- dv/serial_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// two-wire master: owns the clock, pulls data low only
module serial_master_model (
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  int gap = 0; // extra low time, for a slow master
  // idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // one clock; data set while low, seen mid-high
  task automatic clk(input logic pull, output logic q);
    sda_pull = pull;
    #(16 + gap) scl = 1'b1;
    #8 q = sda;
    #8 scl = 1'b0;
    #16;
  endtask : clk
  // start, also repeated start
  task automatic start();
    sda_pull = 1'b0;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b1;
    #16 scl = 1'b0;
    #16;
  endtask : start
  // stop leaves the bus idle
  task automatic stop();
    sda_pull = 1'b1;
    #16 scl = 1'b1;
    #16 sda_pull = 1'b0;
    #48;
  endtask : stop
  // byte out, ack comes back
  task automatic put(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) clk(!b[i], q);
    clk(1'b0, q);
    ack = !q;
  endtask : put
  // byte in, acked unless last
  task automatic get(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      clk(1'b0, q);
      b[i] = q;
    end
    clk(!last, q);
  endtask : get
endmodule : serial_master_model
`default_nettype wire

// ---- dv/tb_wiper_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "wiper_defines.svh"
// bench: master model on the wire, integer register model
module tb_wiper_bank;
  logic mclk, rst, scl, pull, supply_low, ack, sda_out, sda_oe;
  logic [2:0] address_straps;
  logic [7:0] v;
  wiper_pkg::tap_ctrl_type tap_ch0, tap_ch1;
  wire logic sda = !(sda_oe || pull); // pull-up when released
  int errors = 0, tests_run = 0, seed = 82370;
  int model [3]; // ch0, ch1, control
  wiper_bank uut (.mclk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .address_straps, .supply_low, .tap_ch0, .tap_ch1);
  serial_master_model master (.sda, .scl, .sda_pull(pull));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // one compare
  task automatic check(input string what, input logic [7:0] seen, input int exp);
    tests_run++;
    if (seen !== 8'(exp)) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, 8'(exp), seen);
    end
  endtask : check
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // model write, junk control bits dropped
  function automatic void mput(int a, int d);
    if (a < 8'h02) model[a] = d;
    if (a == 8'h10) model[2] = d & 8'h40;
  endfunction : mput
  function automatic int mget(int a);
    return a < 8'h02 ? model[a] : a == 8'h10 ? model[2] : 8'h00;
  endfunction : mget
  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    model = '{`WIPER_RESET, `WIPER_RESET, `ACCESS_CONTROL_RESET};
    repeat (4) @(posedge mclk);
  endtask : do_reset
  // start, write id, register address
  task automatic head(input logic [7:0] a);
    master.start();
    master.put({`ID_PREFIX, address_straps, 1'b0}, ack);
    check("id ack", {7'h0, ack}, 1);
    master.put(a, ack);
    check("addr ack", {7'h0, ack}, 1);
  endtask : head
  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0, d1);
    head(a);
    for (int i = 0; i < n; i++) begin
      master.put(i ? d1 : d0, ack);
      check("data ack", {7'h0, ack}, 1);
      mput(a + i, i ? d1 : d0);
    end
    master.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] b;
    head(a);
    master.start();
    master.put({`ID_PREFIX, address_straps, 1'b1}, ack);
    check("read id ack", {7'h0, ack}, 1);
    for (int i = 0; i < n; i++) begin
      master.get(i == n - 1, b);
      check("read data", b, mget(a + i));
    end
    master.stop();
  endtask : rd
  task automatic taps();
    check("tap ch0", tap_ch0.tap_new, model[0]);
    check("tap ch1", tap_ch1.tap_new, model[1]);
    check("shutdown", {7'h0, tap_ch1.shutdown}, model[2] == 0);
    // old tap only tracks the code while the taps are switched
    if (model[2] != 0) begin
      check("old tap ch0", tap_ch0.tap_old, model[0]);
      check("old tap ch1", tap_ch1.tap_old, model[1]);
      check("break ch0", {7'h0, tap_ch0.break_old}, 1);
      check("break ch1", {7'h0, tap_ch1.break_old}, 1);
    end
  endtask : taps
  task automatic dip(input int n);
    @(posedge mclk);
    supply_low <= 1'b1;
    repeat (n) @(posedge mclk);
    supply_low <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask : dip
  // main sequence
  initial begin
    rst = 1'b1;
    supply_low = 1'b0;
    address_straps = 3'h0;
    do_reset();
    taps();
    rd(8'h00, 3);
    rd(8'h10, 1);
    for (int k = 1; k < 8; k++) begin
      master.start();
      master.put({`ID_PREFIX, address_straps ^ 3'(k), 1'b0}, ack);
      check("foreign id", {7'h0, ack}, 0);
      master.stop();
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge mclk);
      address_straps <= 3'($random(seed));
      master.gap = j * 20;
      repeat (130) @(posedge mclk);
      v = j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'($random(seed));
      wr(8'h00, 2, v, 8'($random(seed)));
      taps();
      rd(8'h00, 2);
    end
    wr(8'h10, 1, 8'($random(seed)) & 8'hbf, 8'h00);
    taps();
    rd(8'h10, 1);
    dip(30);
    taps();
    dip(90);
    model[0] = `WIPER_RESET;
    model[1] = `WIPER_RESET;
    taps();
    wr(8'h01, 1, 8'h5a, 8'h00);
    wr(8'h10, 1, 8'hff, 8'h00);
    check("settling", {7'h0, tap_ch0.shutdown}, 1);
    repeat (300) @(posedge mclk);
    taps();
    dip(90);
    taps();
    do_reset();
    taps();
    rd(8'h10, 1);
    end_of_test();
  end
  // hang guard
  initial begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule : tb_wiper_bank
`default_nettype wire
